// *** smoc_pkg.sv ***
package smoc_pkg;
	// ---------------------------------------------------------------
	// timing at the 20 MHz core clock
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 50;
	// least time the pin must stay low before sleep is taken
	localparam int unsigned SLEEP_ENTRY_NS = 400;
	localparam int unsigned SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// glitch filter: pin must be steady this long before it counts
	localparam int unsigned GLITCH_NS = 200;
	localparam int unsigned GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// restart interval after the pin returns high
	localparam int unsigned RESTART_NS = 1000;
	localparam int unsigned RESTART_CYC = (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 8;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic FILT_RESET = 1'b1;

	// ---------------------------------------------------------------
	// power states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_CONFIG = 3'b000,
		ST_INIT = 3'b001,
		ST_USER = 3'b010,
		ST_ENTER = 3'b011,
		ST_SLEEP = 3'b100,
		ST_RESTART = 3'b101
	} smoc_state_t;
endpackage

// *** smoc_sleep_ctrl.sv ***
`timescale 1ns/1ns
// What this block does
// - standby pin alone selects normal or sleep
// - sleep only on higher-supply variants
// - sleep stops logic, clears state, tristates io
// - test and programming port off in sleep
// - timed sleep entry and restart interval
// - glitch filtered pin with hysteresis, pulled high
// - user mode starts with configured register values
// - config bit enables internal oscillator
// - oscillator runs 18 to 26 MHz
// - oscillator selectable to clock tree or routing
module smoc_sleep_ctrl (
	// clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// standby pin
	input wire logic standby_request_n_i,
	// configuration straps and sequence
	input wire logic sleep_capable_i,
	input wire logic config_done_i,
	input wire logic osc_enable_cfg_i,
	input wire logic osc_route_global_i,
	input wire logic osc_raw_i,
	// status and control towards the fabric
	output logic user_mode_o,
	output logic logic_run_o,
	output logic state_clear_o,
	output logic io_enable_o,
	output logic tap_enable_o,
	output logic config_start_o,
	output logic init_apply_o,
	output logic asleep_o,
	output logic osc_global_o,
	output logic osc_route_o
);
	import smoc_pkg::*;

	// ---------------------------------------------------------------
	// pin synchroniser and glitch filter
	// ---------------------------------------------------------------
	logic sync1_q, sync2_q;
	logic filt_q, filt_d;
	logic [CNT_W-1:0] gcnt_q, gcnt_d;

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= standby_request_n_i;
			sync2_q <= sync1_q;
		end
	end

	always_comb begin
		filt_d = filt_q;
		gcnt_d = CNT_ZERO;
		if (sync2_q != filt_q) begin
			if (gcnt_q == CNT_W'(GLITCH_CYC - 1)) begin
				filt_d = sync2_q;
			end else begin
				gcnt_d = gcnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			filt_q <= FILT_RESET;
			gcnt_q <= CNT_ZERO;
		end else begin
			filt_q <= filt_d;
			gcnt_q <= gcnt_d;
		end
	end

	// ---------------------------------------------------------------
	// power state machine
	// ---------------------------------------------------------------
	smoc_state_t state_q, state_d;
	logic [CNT_W-1:0] tcnt_q, tcnt_d;

	always_comb begin
		state_d = state_q;
		tcnt_d = CNT_ZERO;
		case (state_q)
			ST_CONFIG: begin
				if (config_done_i) begin
					state_d = ST_INIT;
				end
			end
			ST_INIT: begin
				state_d = ST_USER;
			end
			ST_USER: begin
				// relies on pin high during configuration
				if (!filt_q && sleep_capable_i) begin
					state_d = ST_ENTER;
				end
			end
			ST_ENTER: begin
				if (filt_q) begin
					state_d = ST_USER;
				end else if (tcnt_q == CNT_W'(SLEEP_ENTRY_CYC - 1)) begin
					state_d = ST_SLEEP;
				end else begin
					tcnt_d = tcnt_q + 8'h01;
				end
			end
			ST_SLEEP: begin
				if (filt_q) begin
					state_d = ST_RESTART;
				end
			end
			ST_RESTART: begin
				if (tcnt_q == CNT_W'(RESTART_CYC - 1)) begin
					state_d = ST_CONFIG;
				end else begin
					tcnt_d = tcnt_q + 8'h01;
				end
			end
			default: begin
				state_d = ST_CONFIG;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state_q <= ST_CONFIG;
			tcnt_q <= CNT_ZERO;
		end else begin
			state_q <= state_d;
			tcnt_q <= tcnt_d;
		end
	end

	// ---------------------------------------------------------------
	// registered outputs
	// ---------------------------------------------------------------
	logic run_q, clr_q, io_q, tap_q, cfg_q, ini_q, slp_q, usr_q;
	logic run_d, clr_d, io_d, tap_d, cfg_d, ini_d, slp_d, usr_d;

	always_comb begin
		slp_d = (state_d == ST_SLEEP) || (state_d == ST_RESTART);
		usr_d = (state_d == ST_USER) || (state_d == ST_ENTER);
		run_d = usr_d;
		io_d = usr_d;
		clr_d = slp_d;
		tap_d = !slp_d;
		cfg_d = (state_d == ST_CONFIG);
		ini_d = (state_d == ST_INIT);
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			slp_q <= 1'b0;
			usr_q <= 1'b0;
			run_q <= 1'b0;
			io_q <= 1'b0;
			clr_q <= 1'b0;
			tap_q <= 1'b1;
			cfg_q <= 1'b1;
			ini_q <= 1'b0;
		end else begin
			slp_q <= slp_d;
			usr_q <= usr_d;
			run_q <= run_d;
			io_q <= io_d;
			clr_q <= clr_d;
			tap_q <= tap_d;
			cfg_q <= cfg_d;
			ini_q <= ini_d;
		end
	end

	assign asleep_o = slp_q;
	assign user_mode_o = usr_q;
	assign logic_run_o = run_q;
	assign io_enable_o = io_q;
	assign state_clear_o = clr_q;
	assign tap_enable_o = tap_q;
	assign config_start_o = cfg_q;
	assign init_apply_o = ini_q;

	// ---------------------------------------------------------------
	// oscillator gating and routing
	// ---------------------------------------------------------------
	// enable bit gates oscillator
	// raw 18-26 MHz source passed through
	assign osc_global_o = osc_raw_i & osc_enable_cfg_i & osc_route_global_i;
	assign osc_route_o = osc_raw_i & osc_enable_cfg_i & ~osc_route_global_i;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_wake;
		(state_q == ST_SLEEP) && filt_q;
	endsequence

	property p_pin_rules;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(state_q == ST_USER && filt_q) |=> state_q != ST_ENTER;
	endproperty
	a_pin_rules: assert property (p_pin_rules) else $error("sleep entry with pin high");

	property p_variant;
		@(posedge mclk_i) disable iff (sys_rst_i)
		!sleep_capable_i && state_q == ST_USER |=> state_q == ST_USER;
	endproperty
	a_variant: assert property (p_variant) else $error("sleep on incapable variant");

	property p_sleep_io;
		@(posedge mclk_i) disable iff (sys_rst_i)
		asleep_o |-> !io_enable_o && !logic_run_o && state_clear_o;
	endproperty
	a_sleep_io: assert property (p_sleep_io) else $error("io or logic active in sleep");

	property p_tap_off;
		@(posedge mclk_i) disable iff (sys_rst_i)
		asleep_o |-> !tap_enable_o;
	endproperty
	a_tap_off: assert property (p_tap_off) else $error("tap active in sleep");

	property p_entry_time;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(state_q == ST_USER && state_d == ST_ENTER) |=> !asleep_o [*8];
	endproperty
	a_entry_time: assert property (p_entry_time) else $error("sleep entered too soon");

	property p_filter;
		@(posedge mclk_i) disable iff (sys_rst_i)
		$changed(filt_q) |-> $past(sync2_q, 1) == filt_q && $past(sync2_q, 4) == filt_q;
	endproperty
	a_filter: assert property (p_filter) else $error("filter passed a short pulse");

	property p_init;
		@(posedge mclk_i) disable iff (sys_rst_i)
		$rose(user_mode_o) |-> $past(init_apply_o);
	endproperty
	a_init: assert property (p_init) else $error("user mode without initial states");

	property p_osc;
		@(posedge mclk_i) disable iff (sys_rst_i)
		!osc_enable_cfg_i |-> !osc_global_o && !osc_route_o;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator out while disabled");

	property p_rewake;
		@(posedge mclk_i) disable iff (sys_rst_i)
		s_wake |-> ##[20:22] config_start_o;
	endproperty
	a_rewake: assert property (p_rewake) else $error("no reconfiguration after wake");
endmodule

// *** smoc_standby_model.sv ***
`timescale 1ns/1ns
module smoc_standby_model (
	// clock
	input wire logic mclk_i,
	// request and device status
	input wire logic sleep_req_i,
	input wire logic config_start_i,
	// standby pin
	output logic standby_request_n_o
);
	// ----------------------------------------
	// pin driver
	// ----------------------------------------
	// pin idles high
	initial standby_request_n_o = 1'b1;
	always @(posedge mclk_i) begin
		standby_request_n_o <= !(sleep_req_i && !config_start_i);
	end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;
	logic mclk_i, sys_rst_i, pin_n, sleep_req, sleep_capable_i, config_done_i;
	logic osc_enable_cfg_i, osc_route_global_i, osc_raw_i, osc_global_o, osc_route_o;
	logic user_mode_o, logic_run_o, state_clear_o, io_enable_o, tap_enable_o;
	logic config_start_o, init_apply_o, asleep_o, hit;
	logic [7:0] stat;
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;
	// osc table: {enable, to_tree, raw, tree_out, route_out}
	logic [4:0] rows [8] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h15, 5'h18, 5'h1E};
	assign stat = {user_mode_o, logic_run_o, state_clear_o, io_enable_o, tap_enable_o,
		config_start_o, init_apply_o, asleep_o};
	smoc_sleep_ctrl dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .standby_request_n_i(pin_n),
		.sleep_capable_i(sleep_capable_i), .config_done_i(config_done_i),
		.osc_enable_cfg_i(osc_enable_cfg_i), .osc_route_global_i(osc_route_global_i),
		.osc_raw_i(osc_raw_i), .user_mode_o(user_mode_o), .logic_run_o(logic_run_o),
		.state_clear_o(state_clear_o), .io_enable_o(io_enable_o), .tap_enable_o(tap_enable_o),
		.config_start_o(config_start_o), .init_apply_o(init_apply_o), .asleep_o(asleep_o),
		.osc_global_o(osc_global_o), .osc_route_o(osc_route_o));
	smoc_standby_model ctrl (.mclk_i(mclk_i), .sleep_req_i(sleep_req),
		.config_start_i(config_start_o), .standby_request_n_o(pin_n));
	// ----------------------------------------
	// clock and watchdog
	// ----------------------------------------
	initial begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			print_verdict();
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_bit(input int idx, input logic v, input int lim, output logic found);
		found = 1'b0;
		for (int n = 0; n < lim && !found; n++) begin
			@(negedge mclk_i);
			if (stat[idx] === v)
				found = 1'b1;
		end
	endtask
	task automatic pulse(input int n);
		@(posedge mclk_i) sleep_req <= 1'b1;
		repeat (n) @(posedge mclk_i);
		sleep_req <= 1'b0;
	endtask
	task automatic boot();
		@(posedge mclk_i) config_done_i <= 1'b1;
		@(posedge mclk_i) config_done_i <= 1'b0;
		wait_bit(1, 1'b1, 3, hit);
		check({7'h00, hit}, 8'h01);
		@(negedge mclk_i);
		check(stat, 8'hD8);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		sys_rst_i = 1'b1;
		sleep_req = 1'b0;
		sleep_capable_i = 1'b1;
		config_done_i = 1'b0;
		osc_enable_cfg_i = 1'b0;
		osc_route_global_i = 1'b0;
		osc_raw_i = 1'b0;
		repeat (19) @(negedge mclk_i);
		check(stat, 8'h0C);
		@(posedge mclk_i) sys_rst_i <= 1'b0;
		boot();
		foreach (rows[i]) begin
			@(posedge mclk_i) {osc_enable_cfg_i, osc_route_global_i, osc_raw_i} <= rows[i][4:2];
			@(negedge mclk_i) check({6'h00, osc_global_o, osc_route_o}, {6'h00, rows[i][1:0]});
		end
		pulse(3);
		wait_bit(0, 1'b1, 30, hit);
		check({7'h00, hit}, 8'h00);
		pulse(6);
		wait_bit(0, 1'b1, 30, hit);
		check({7'h00, hit}, 8'h00);
		@(posedge mclk_i) sleep_capable_i <= 1'b0;
		pulse(30);
		wait_bit(0, 1'b1, 30, hit);
		check({7'h00, hit}, 8'h00);
		@(posedge mclk_i) sleep_capable_i <= 1'b1;
		sleep_req <= 1'b1;
		wait_bit(0, 1'b1, 12, hit);
		check({7'h00, hit}, 8'h00);
		wait_bit(0, 1'b1, 10, hit);
		check({7'h00, hit}, 8'h01);
		check(stat, 8'h21);
		@(posedge mclk_i) sleep_req <= 1'b0;
		wait_bit(0, 1'b0, 22, hit);
		check({7'h00, hit}, 8'h00);
		wait_bit(2, 1'b1, 15, hit);
		check({7'h00, hit}, 8'h01);
		check(stat, 8'h0C);
		boot();
		print_verdict();
	end
endmodule
